// >>> mxb_params.svh
// Timing counts and bus width for the muxed external bus
`ifndef MXB_PARAMS_SVH
`define MXB_PARAMS_SVH
`define MXB_BUS_W 16
// Oscillator period in ns, and one oscillator period in clk_sys cycles
`define MXB_TOSC_NS 20
`define MXB_CLK_NS 20
`define MXB_TOSC_CYC ((`MXB_TOSC_NS + `MXB_CLK_NS - 1) / `MXB_CLK_NS)
// State time is three oscillator periods
`define MXB_STATE_TOSC 3
// Phase lengths in oscillator periods
`define MXB_ALE_TOSC 1
`define MXB_ADDR_HOLD_TOSC 1
`define MXB_RD_TOSC 1
`define MXB_RD_REC_TOSC 1
`define MXB_WR_TOSC 2
`define MXB_WR_REC_TOSC 2
`define MXB_CNT_W 4
`endif

// >>> mxb_pkg.sv
// Types for the muxed external bus
package mxb_pkg;
  typedef enum logic [7:0] {
    MXB_IDLE = 8'h01,
    MXB_ALE = 8'h02,
    MXB_HOLD = 8'h04,
    MXB_RD = 8'h08,
    MXB_RREC = 8'h10,
    MXB_WR = 8'h20,
    MXB_WREC = 8'h40
  } mxb_state_t;
endpackage

// >>> mxb_sync.sv
// Two-flop synchroniser for the ready pin
`timescale 1ns/10ps
module mxb_sync
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic q_ff;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule // mxb_sync

// >>> mxb_clkgen.sv
// State clock generator: period three Tosc, high for one
`timescale 1ns/10ps
`include "mxb_params.svh"
module mxb_clkgen
(
  input wire logic clk_sys,
  input wire logic rst_b,
  output logic state_clock_out,
  output logic tosc_tick
);
  logic [`MXB_CNT_W-1:0] div_ff;
  logic [1:0] ph_ff;
  logic clk_ff;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      div_ff <= 4'h0;
    else if (div_ff == 4'(`MXB_TOSC_CYC - 1))
      div_ff <= 4'h0;
    else
      div_ff <= div_ff + 4'h1;
  end
  assign tosc_tick = (div_ff == 4'(`MXB_TOSC_CYC - 1));
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ph_ff <= 2'h0;
    else if (tosc_tick)
      ph_ff <= (ph_ff == 2'(`MXB_STATE_TOSC - 1)) ? 2'h0 : ph_ff + 2'h1;
  end
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      clk_ff <= 1'b0;
    else if (tosc_tick)
      clk_ff <= (ph_ff == 2'(`MXB_STATE_TOSC - 1));
  end
  assign state_clock_out = clk_ff;
endmodule // mxb_clkgen

// >>> mxb_bus.sv
// Muxed 16-bit address/data external bus master
`timescale 1ns/10ps
`include "mxb_params.svh"
// How it works
// - Address and data share one latched bus
// - Fetch indicator high for instruction fetches
// - Byte lanes chosen by address bit zero and high enable
// - Reads drive enables, unused byte dropped
// - Ready low stretches cycle with waits
// - State clock three Tosc, high one
// - Strobe one Tosc, address held around
// - Strobes start one Tosc after latch
// - Read one Tosc, then latch after one
// - Write two Tosc, data held, recovery two
module mxb_bus
  import mxb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_fetch,
  input wire logic [15:0] req_addr,
  input wire logic [1:0] req_bytes,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  input wire logic [15:0] ad_in,
  output logic [15:0] ad_out,
  output logic ad_oe,
  output logic addr_latch_strobe,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic fetch_indicator,
  output logic high_byte_enable_n,
  input wire logic ready_in,
  output logic state_clock_out
);
  // ------------------------------------------------------------
  // Clocking and pin synchronisation
  // ------------------------------------------------------------
  logic tosc_tick;
  logic ready_sync;
  logic sclk;
  mxb_clkgen u_clkgen
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .state_clock_out(sclk),
    .tosc_tick(tosc_tick)
  );
  mxb_sync u_sync
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d(ready_in),
    .q(ready_sync)
  );
  // ------------------------------------------------------------
  // Cycle sequencer
  // ------------------------------------------------------------
  mxb_state_t state_ff;
  mxb_state_t nxt_state;
  logic [15:0] addr_ff;
  logic [15:0] wdata_ff;
  logic write_ff;
  logic [1:0] bytes_ff;
  logic [15:0] ad_out_ff;
  logic ad_oe_ff;
  logic ale_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic fetch_ind_ff;
  logic bhe_n_ff;
  logic req_ready_ff;
  logic rsp_valid_ff;
  logic [15:0] rdata_ff;
  logic sclk_ff;
  logic take;

  // Lane select: bit 0 high means upper byte only
  function automatic logic [15:0] mxb_lane_addr
  (
    input logic [15:0] a,
    input logic [1:0] b
  );
    mxb_lane_addr = (b == 2'h2) ? {a[15:1], 1'b1} : {a[15:1], 1'b0};
  endfunction

  function automatic logic mxb_bhe_n
  (
    input logic [1:0] b
  );
    mxb_bhe_n = ~b[1];
  endfunction

  assign take = tosc_tick && (state_ff == MXB_IDLE) && req_valid;

  // Every phase lasts whole Tosc; write and its recovery last two
  logic [1:0] ph_cnt_ff;
  logic ph_last;
  always_comb
  begin
    ph_last = 1'b1;
    case (state_ff)
      MXB_WR: ph_last = (ph_cnt_ff == 2'(`MXB_WR_TOSC - 1));
      MXB_WREC: ph_last = (ph_cnt_ff == 2'(`MXB_WR_REC_TOSC - 1));
      default: ph_last = 1'b1;
    endcase
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      MXB_IDLE:
      begin
        if (req_valid)
          nxt_state = MXB_ALE;
      end
      MXB_ALE: nxt_state = MXB_HOLD;
      MXB_HOLD: nxt_state = write_ff ? MXB_WR : MXB_RD;
      MXB_RD:
      begin
        if (ready_sync)
          nxt_state = MXB_RREC;
      end
      MXB_RREC: nxt_state = MXB_IDLE;
      MXB_WR:
      begin
        if (ph_last && ready_sync)
          nxt_state = MXB_WREC;
      end
      MXB_WREC:
      begin
        if (ph_last)
          nxt_state = MXB_IDLE;
      end
      default: nxt_state = MXB_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      state_ff <= MXB_IDLE;
    else if (tosc_tick)
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ph_cnt_ff <= 2'h0;
    else if (tosc_tick)
    begin
      if (nxt_state != state_ff)
        ph_cnt_ff <= 2'h0;
      else if (!ph_last)
        ph_cnt_ff <= ph_cnt_ff + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // Request capture
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_ff <= 16'h0000;
      wdata_ff <= 16'h0000;
      write_ff <= 1'b0;
      bytes_ff <= 2'h3;
    end
    else if (take)
    begin
      addr_ff <= mxb_lane_addr(req_addr, req_bytes);
      wdata_ff <= req_wdata;
      write_ff <= req_write;
      bytes_ff <= (req_bytes == 2'h0) ? 2'h3 : req_bytes;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      req_ready_ff <= 1'b0;
    else
      req_ready_ff <= take;
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  // Address driven one Tosc before and after the latch strobe falls
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ad_out_ff <= 16'h0000;
      ad_oe_ff <= 1'b0;
    end
    else if (tosc_tick)
    begin
      case (nxt_state)
        MXB_ALE, MXB_HOLD:
        begin
          ad_out_ff <= mxb_lane_addr(
            (state_ff == MXB_IDLE) ? req_addr : addr_ff,
            (state_ff == MXB_IDLE) ? req_bytes : bytes_ff);
          ad_oe_ff <= 1'b1;
        end
        MXB_WR, MXB_WREC:
        begin
          // Data held through recovery covers the post-rise hold
          ad_out_ff <= wdata_ff;
          ad_oe_ff <= 1'b1;
        end
        default:
        begin
          // Bus released so memory may answer a read
          ad_out_ff <= 16'h0000;
          ad_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      fetch_ind_ff <= 1'b0;
      bhe_n_ff <= 1'b1;
    end
    else if (tosc_tick)
    begin
      ale_ff <= (nxt_state == MXB_ALE);
      rd_n_ff <= ~(nxt_state == MXB_RD);
      wr_n_ff <= ~(nxt_state == MXB_WR);
      if (nxt_state == MXB_ALE)
      begin
        fetch_ind_ff <= req_fetch & ~req_write;
        // Enables driven on reads too; unused byte dropped later
        bhe_n_ff <= mxb_bhe_n((req_bytes == 2'h0) ? 2'h3 : req_bytes);
      end
    end
  end

  // ------------------------------------------------------------
  // Read data return
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp_valid_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end
    else
    begin
      rsp_valid_ff <= tosc_tick && (state_ff == MXB_RD) && ready_sync;
      if (tosc_tick && (state_ff == MXB_RD) && ready_sync)
      begin
        // Upper-only read returns high byte in low lane
        if (bytes_ff == 2'h2)
          rdata_ff <= {8'h00, ad_in[15:8]};
        else if (bytes_ff == 2'h1)
          rdata_ff <= {8'h00, ad_in[7:0]};
        else
          rdata_ff <= ad_in;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      sclk_ff <= 1'b0;
    else
      sclk_ff <= sclk;
  end

  assign req_ready = req_ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rdata_ff;
  assign ad_out = ad_out_ff;
  assign ad_oe = ad_oe_ff;
  assign addr_latch_strobe = ale_ff;
  assign read_strobe_n = rd_n_ff;
  assign write_strobe_n = wr_n_ff;
  assign fetch_indicator = fetch_ind_ff;
  assign high_byte_enable_n = bhe_n_ff;
  assign state_clock_out = sclk_ff;
endmodule // mxb_bus

// >>> mxb_checker.sv
// Bus timing checker for the muxed external bus
`timescale 1ns/10ps
module mxb_checker
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [15:0] ad_out,
  input wire logic ad_oe,
  input wire logic addr_latch_strobe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic state_clock_out
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  a_ale_width: assert property ($rose(addr_latch_strobe) |=>
    !addr_latch_strobe) else $error("ale too long");
  a_addr_setup: assert property (addr_latch_strobe |-> ad_oe)
    else $error("no address");
  a_addr_hold: assert property ($fell(addr_latch_strobe) |->
    ad_oe && $stable(ad_out)) else $error("address not held");
  a_strobe_gap: assert property ($fell(addr_latch_strobe) |->
    read_strobe_n && write_strobe_n ##1
    (read_strobe_n != write_strobe_n)) else $error("strobe late");
  a_strobe_excl: assert property (!(!read_strobe_n &&
    !write_strobe_n)) else $error("read and write");
  a_addr_quiet: assert property (addr_latch_strobe |->
    read_strobe_n && write_strobe_n) else $error("strobe in address");
  a_rd_float: assert property (!read_strobe_n |-> !ad_oe)
    else $error("driving during read");
  a_rd_recover: assert property ($rose(read_strobe_n) |->
    !addr_latch_strobe) else $error("ale after read early");
  a_wr_width: assert property ($fell(write_strobe_n) |=>
    !write_strobe_n) else $error("write short");
  a_wr_hold: assert property ($rose(write_strobe_n) |->
    ad_oe && $stable(ad_out) && !addr_latch_strobe ##1
    !addr_latch_strobe) else $error("write hold");
  a_sclk_period: assert property ($rose(state_clock_out) |=>
    !state_clock_out ##1 !state_clock_out ##1 state_clock_out)
    else $error("state clock");
endmodule // mxb_checker

bind mxb_bus mxb_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .ad_out(ad_out), .ad_oe(ad_oe), .addr_latch_strobe(addr_latch_strobe),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .state_clock_out(state_clock_out));

// >>> mxb_mem_model.sv
// External memory behind address latches, with wait states
`timescale 1ns/10ps
module mxb_mem_model
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [15:0] ad_out,
  input wire logic addr_latch_strobe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic high_byte_enable_n,
  input wire logic [3:0] wait_cnt,
  output logic [15:0] ad_in,
  output logic ready_in
);
  logic [15:0] mem [8];
  logic [15:0] addr_ff;
  logic [15:0] last_ff;
  logic bhe_n_ff;
  logic hold_ff;
  logic [3:0] wait_ff;
  // Both bytes always returned; floated bus toggles
  assign ad_in = (!read_strobe_n || hold_ff) ? mem[addr_ff[3:1]] :
    ~last_ff;
  // Pulled low during the strobe so the sync sees it
  assign ready_in = !(addr_latch_strobe && wait_cnt != 4'h0) &&
    wait_ff == 4'h0;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      hold_ff <= 1'b0;
      last_ff <= 16'h0;
      wait_ff <= 4'h0;
    end
    else
    begin
      hold_ff <= !read_strobe_n;
      last_ff <= ad_in;
      if (addr_latch_strobe)
        wait_ff <= wait_cnt;
      else if (wait_ff != 4'h0)
        wait_ff <= wait_ff - 4'h1;
    end
  always_ff @(posedge clk_sys)
    if (addr_latch_strobe)
    begin
      addr_ff <= ad_out;
      bhe_n_ff <= high_byte_enable_n;
    end
  always_ff @(posedge clk_sys)
    if (!write_strobe_n)
    begin
      if (!addr_ff[0])
        mem[addr_ff[3:1]][7:0] <= ad_out[7:0];
      if (!bhe_n_ff)
        mem[addr_ff[3:1]][15:8] <= ad_out[15:8];
    end
endmodule // mxb_mem_model

// >>> tb.sv
// Self-checking bench for the muxed external bus
`timescale 1ns/10ps
module tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_fetch = 1'b0;
  logic [15:0] req_addr = 16'h0;
  logic [1:0] req_bytes = 2'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [3:0] wait_cnt = 4'h0;
  logic req_ready, rsp_valid, ad_oe, addr_latch_strobe, ready_in;
  logic read_strobe_n, write_strobe_n, fetch_indicator;
  logic high_byte_enable_n, state_clock_out;
  logic [15:0] rsp_rdata, ad_in, ad_out, q;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int lo;
  always #10 clk_sys = ~clk_sys;
  mxb_bus uut (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid),
    .req_write(req_write), .req_fetch(req_fetch), .req_addr(req_addr),
    .req_bytes(req_bytes), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ad_in(ad_in),
    .ad_out(ad_out), .ad_oe(ad_oe), .addr_latch_strobe(addr_latch_strobe),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .fetch_indicator(fetch_indicator), .ready_in(ready_in),
    .high_byte_enable_n(high_byte_enable_n),
    .state_clock_out(state_clock_out));
  mxb_mem_model u_mem (.clk_sys(clk_sys), .rst_b(rst_b), .ad_out(ad_out),
    .addr_latch_strobe(addr_latch_strobe), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .wait_cnt(wait_cnt), .ad_in(ad_in),
    .high_byte_enable_n(high_byte_enable_n), .ready_in(ready_in));
  task automatic final_report;
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  // One transfer; strobe low cycles counted at falling edges
  task automatic xfer(input logic wr, fe, input logic [15:0] a, d,
    input logic [1:0] b, input logic [3:0] w);
    int i;
    lo = 0;
    @(negedge clk_sys);
    wait_cnt = w;
    req_write = wr;
    req_fetch = fe;
    req_addr = a;
    req_bytes = b;
    req_wdata = d;
    req_valid = 1'b1;
    for (i = 0; i < 20 && req_ready !== 1'b1; i++)
      @(negedge clk_sys);
    req_valid = 1'b0;
    chk("taken", {15'h0, req_ready}, 16'h1);
    chk("ale", {15'h0, addr_latch_strobe}, 16'h1);
    chk("addr", ad_out, a);
    chk("fetch", {15'h0, fetch_indicator}, {15'h0, fe});
    chk("bhe_n", {15'h0, high_byte_enable_n}, {15'h0, b == 2'h1});
    for (i = 0; i < 40 && (wr ? ad_oe !== 1'b0 : rsp_valid !== 1'b1); i++)
    begin
      @(negedge clk_sys);
      lo += wr ? !write_strobe_n : !read_strobe_n;
    end
    chk("done", {15'h0, i < 40}, 16'h1);
    q = rsp_rdata;
  endtask
  task automatic t_word;
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, 1'b0, 16'h0100 + 16'(2 * k), 16'hC3A5 ^ 16'(k), 2'h3, 4'h0);
      chk("wr_lo", 16'(lo), 16'h2);
      xfer(1'b0, 1'b0, 16'h0100 + 16'(2 * k), 16'h0, 2'h3, 4'h0);
      chk("rd_lo", 16'(lo), 16'h1);
      chk("word", q, 16'hC3A5 ^ 16'(k));
    end
  endtask
  task automatic t_bytes;
    xfer(1'b1, 1'b0, 16'h0208, 16'h0000, 2'h0, 4'h0);
    xfer(1'b1, 1'b0, 16'h0208, 16'h33AA, 2'h1, 4'h0);
    xfer(1'b1, 1'b0, 16'h0209, 16'h55CC, 2'h2, 4'h0);
    xfer(1'b0, 1'b1, 16'h0208, 16'h0, 2'h3, 4'h0);
    chk("merge", q, 16'h55AA);
    xfer(1'b0, 1'b0, 16'h0208, 16'h0, 2'h1, 4'h0);
    chk("low", q, 16'h00AA);
    xfer(1'b0, 1'b0, 16'h0209, 16'h0, 2'h2, 4'h0);
    chk("high", q, 16'h0055);
  endtask
  task automatic t_wait;
    xfer(1'b1, 1'b0, 16'h020C, 16'h9E61, 2'h3, 4'h3);
    chk("wr_wait", {15'h0, lo > 2}, 16'h1);
    xfer(1'b0, 1'b0, 16'h020C, 16'h0, 2'h3, 4'h3);
    chk("rd_wait", {15'h0, lo > 1}, 16'h1);
    chk("wait_data", q, 16'h9E61);
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      final_report;
    end
  end
  initial
  begin
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    t_word;
    t_bytes;
    t_wait;
    final_report;
  end
endmodule // tb
